/* shared/bep_cfg.svh */
// constants of the byte eeprom host port
// What this block does
// - word select lines pick exactly one stored byte per access
// - chip select high keeps byte lines floating and ignores write strobe
// - drive byte only with select low, gate low, strobe high
// - write strobe ignored while deselected, no program cycle starts
// - write strobe low pulse starts program, data taken on rising edge
// - multiplexed bus: address on latch strobe fall, data on strobe rise
// - ready low while programming, high when readable
// - programming paced by the timing input
// - latched address and data held for the whole program cycle
// - ready drops within the status delay after strobe ends
// - all inputs except the timing input and reset disregarded during programming, save address and latch strobe still steering the undriven read byte
// - busy lasts 1024 periods of the timing input
`ifndef BEP_CFG_SVH
`define BEP_CFG_SVH
`define BEP_WORDS 128
`define BEP_ADDR_W 7
`define BEP_DATA_W 8
`define BEP_PROG_PERIODS 1024
`define BEP_PROG_CNT_W 11
`define BEP_ERASED_BYTE 8'hff
`endif

/* shared/bep_pkg.sv */
// types of the byte eeprom host port
`include "bep_cfg.svh"
package bep_pkg;
	typedef enum logic [1:0] {
		BEP_IDLE = 2'b00,
		BEP_PROG = 2'b01,
		BEP_DONE = 2'b10
	} bep_state_type;
	typedef struct packed {
		logic [`BEP_ADDR_W-1:0] addr;
		logic [`BEP_DATA_W-1:0] data;
	} bep_req_type;
endpackage

/* src/bep_eeprom.sv */
// byte eeprom host port with self-timed programming
`timescale 1ns/100ps
`include "bep_cfg.svh"
module bep_eeprom #(
	parameter int AW    = `BEP_ADDR_W,
	parameter int DW    = `BEP_DATA_W,
	parameter int WORDS = `BEP_WORDS
) (
	input  wire logic          clk_sys,
	input  wire logic          reset_n,
	input  wire logic          chip_sel_n,
	input  wire logic          out_gate_n,
	input  wire logic          wr_strobe_n,
	input  wire logic          addr_latch,
	input  wire logic [AW-1:0] word_select_lines,
	input  wire logic [DW-1:0] byte_io_lines_in,
	output logic      [DW-1:0] byte_io_lines_out,
	output logic               byte_io_lines_oe,
	input  wire logic          prog_timing,
	output logic               ready
);
	logic [4:0] s1_r, s2_r;
	logic [AW-1:0] a1_r, a2_r;
	logic [DW-1:0] d1_r, d2_r;
	logic cs_n, oe_n, we_n, ale, tim, we_d_r, ale_d_r, tim_d_r;
	bep_pkg::bep_state_type state_r;
	bep_pkg::bep_req_type latch_r;
	logic [`BEP_PROG_CNT_W-1:0] cnt_r;
	logic [DW-1:0] mem_r [WORDS];
	logic [DW-1:0] rd_r;
	logic drive_r;
	logic busy;
	logic we_rise, ale_fall, tim_rise;
	logic rd_cond;
	logic [`BEP_PROG_CNT_W-1:0] prog_edge_r;

	// two-flop synchronisers on all input pins except reset_n
	always_ff @(posedge clk_sys) begin
		s1_r <= {chip_sel_n, out_gate_n, wr_strobe_n, addr_latch, prog_timing};
		s2_r <= s1_r;
		a1_r <= word_select_lines;
		a2_r <= a1_r;
		d1_r <= byte_io_lines_in;
		d2_r <= d1_r;
	end
	assign {cs_n, oe_n, we_n, ale, tim} = s2_r;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			we_d_r  <= 1'b1;
			ale_d_r <= 1'b1;
			tim_d_r <= 1'b0;
		end else begin
			we_d_r  <= we_n;
			ale_d_r <= ale;
			tim_d_r <= tim;
		end
	end
	assign busy     = (state_r != bep_pkg::BEP_IDLE);
	assign we_rise  = we_n && !we_d_r && !cs_n && !busy;
	assign ale_fall = !ale && ale_d_r && !cs_n && !busy;
	assign tim_rise = tim && !tim_d_r;
	assign rd_cond  = !cs_n && !oe_n && we_n;

	// address on latch fall, data on strobe rise, held while busy
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			latch_r <= '0;
		end else begin
			if (ale_fall) begin
				latch_r.addr <= a2_r;
			end
			if (we_rise) begin
				latch_r.data <= d2_r;
			end
		end
	end

	// programming sequencer
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r <= bep_pkg::BEP_IDLE;
			cnt_r   <= '0;
		end else begin
			case (state_r)
				bep_pkg::BEP_IDLE: begin
					cnt_r <= '0;
					if (we_rise) begin
						state_r <= bep_pkg::BEP_PROG;
					end
				end
				bep_pkg::BEP_PROG: begin
					if (tim_rise) begin
						cnt_r <= cnt_r + 1'b1;
						if (cnt_r == `BEP_PROG_CNT_W'(`BEP_PROG_PERIODS - 1)) begin
							state_r <= bep_pkg::BEP_DONE;
						end
					end
				end
				bep_pkg::BEP_DONE: begin
					state_r <= bep_pkg::BEP_IDLE;
				end
				default: begin
					state_r <= bep_pkg::BEP_IDLE;
				end
			endcase
		end
	end

	// storage written at end of cycle
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_r[i] <= `BEP_ERASED_BYTE;
			end
		end else if (state_r == bep_pkg::BEP_DONE) begin
			mem_r[latch_r.addr] <= latch_r.data;
		end
	end

	// read path: live address while latch strobe high, else latched one
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rd_r    <= '0;
			drive_r <= 1'b0;
		end else begin
			rd_r    <= mem_r[ale ? a2_r : latch_r.addr];
			drive_r <= rd_cond && !busy;
		end
	end
	assign byte_io_lines_out = rd_r;
	assign byte_io_lines_oe  = drive_r;
	assign ready = !busy;

	// timing edges seen during the busy period, for the checks below
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !busy) begin
			prog_edge_r <= '0;
		end else if (tim_rise) begin
			prog_edge_r <= prog_edge_r + 1'b1;
		end
	end

	property p_ready_drop;
		@(posedge clk_sys) disable iff (!reset_n)
		we_rise |=> !ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop)
		else $error("ready did not drop after write strobe");
	property p_no_drive_deselected;
		@(posedge clk_sys) disable iff (!reset_n)
		cs_n |=> !byte_io_lines_oe;
	endproperty
	a_no_drive_deselected: assert property (p_no_drive_deselected)
		else $error("byte lines driven while deselected");
	property p_drive_cond;
		@(posedge clk_sys) disable iff (!reset_n)
		byte_io_lines_oe |-> $past(rd_cond);
	endproperty
	a_drive_cond: assert property (p_drive_cond)
		else $error("byte lines driven outside read");
	property p_no_start_deselected;
		@(posedge clk_sys) disable iff (!reset_n)
		(ready && cs_n) |=> ready;
	endproperty
	a_no_start_deselected: assert property (p_no_start_deselected)
		else $error("program started while deselected");
	property p_hold_latch;
		@(posedge clk_sys) disable iff (!reset_n)
		(!ready && !$past(ready)) |-> $stable(latch_r);
	endproperty
	a_hold_latch: assert property (p_hold_latch)
		else $error("latched request changed while busy");
	property p_data_capture;
		@(posedge clk_sys) disable iff (!reset_n)
		we_rise |=> latch_r.data == $past(d2_r);
	endproperty
	a_data_capture: assert property (p_data_capture)
		else $error("data not captured on strobe rise");
	property p_addr_capture;
		@(posedge clk_sys) disable iff (!reset_n)
		ale_fall |=> latch_r.addr == $past(a2_r);
	endproperty
	a_addr_capture: assert property (p_addr_capture)
		else $error("address not captured on latch fall");
	property p_count_pace;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == bep_pkg::BEP_PROG && !tim_rise) |=> $stable(cnt_r);
	endproperty
	a_count_pace: assert property (p_count_pace)
		else $error("program counter moved without timing edge");
	property p_no_drive_busy;
		@(posedge clk_sys) disable iff (!reset_n)
		!ready |=> !byte_io_lines_oe;
	endproperty
	a_no_drive_busy: assert property (p_no_drive_busy)
		else $error("read answered while busy");
	c_prog: cover property (@(posedge clk_sys) disable iff (!reset_n)
		state_r == bep_pkg::BEP_DONE);
	c_read: cover property (@(posedge clk_sys) disable iff (!reset_n)
		byte_io_lines_oe);
	c_mux_addr: cover property (@(posedge clk_sys) disable iff (!reset_n)
		ale_fall ##[1:20] we_rise);
	c_mux_read: cover property (@(posedge clk_sys) disable iff (!reset_n)
		ale_fall ##[1:20] byte_io_lines_oe);
	c_strobe_busy: cover property (@(posedge clk_sys) disable iff (!reset_n)
		busy && we_n && !we_d_r);
	property p_prog_len;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == bep_pkg::BEP_DONE) |->
			(prog_edge_r == `BEP_PROG_CNT_W'(`BEP_PROG_PERIODS));
	endproperty
	a_prog_len: assert property (p_prog_len)
		else $error("busy period not equal to programming edge count");
	property p_busy_hold;
		@(posedge clk_sys) disable iff (!reset_n)
		(!ready && prog_edge_r < `BEP_PROG_CNT_W'(`BEP_PROG_PERIODS))
			|=> !ready;
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("ready returned before programming finished");
	property p_commit;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == bep_pkg::BEP_DONE) |=>
			(mem_r[$past(latch_r.addr)] == $past(latch_r.data));
	endproperty
	a_commit: assert property (p_commit)
		else $error("latched byte not stored at latched word");
	property p_start_strobe;
		@(posedge clk_sys) disable iff (!reset_n)
		(ready && !we_rise) |=> ready;
	endproperty
	a_start_strobe: assert property (p_start_strobe)
		else $error("program started without write strobe");
	property p_busy_ignores_strobe;
		@(posedge clk_sys) disable iff (!reset_n)
		(state_r == bep_pkg::BEP_PROG && !tim_rise && we_n && !we_d_r)
			|=> (state_r == bep_pkg::BEP_PROG && $stable(cnt_r));
	endproperty
	a_busy_ignores_strobe: assert property (p_busy_ignores_strobe)
		else $error("write strobe disturbed a running program cycle");
endmodule

/* testbench/bep_host.sv */
// host bus model driving the eeprom pins
`timescale 1ns/100ps
module bep_host (
	input  wire logic       clk_sys,
	output logic            cs_n,
	output logic            oe_n,
	output logic            we_n,
	output logic            al,
	output logic [6:0]      a,
	output logic [7:0]      di,
	output logic            pt,
	input  wire logic [7:0] q,
	input  wire logic       qe
);
	initial begin
		{cs_n, oe_n, we_n, al} = 4'hf;
		a = 7'h00;
		di = 8'h00;
		pt = 1'b0;
		forever #40 pt = ~pt;
	end
	task cyc(int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task wr(input logic [6:0] x, logic [7:0] d, logic c, m);
		cyc(1);
		cs_n = c;
		a = x;
		di = d;
		al = 1'b1;
		cyc(6);
		if (m) begin
			al = 1'b0;
			cyc(6);
			a = ~x;
		end
		we_n = 1'b0;
		al = 1'b0;
		cyc(6);
		we_n = 1'b1;
		al = 1'b1;
		cyc(6);
		cs_n = 1'b1;
		di = ~d;
	endtask
	task rd(input logic [6:0] x, logic c, g, m, output logic [7:0] r, e);
		cyc(1);
		cs_n = c;
		a = x;
		al = 1'b1;
		if (m) begin
			cyc(6);
			al = 1'b0;
			cyc(6);
			a = ~x;
		end
		oe_n = g;
		cyc(6);
		r = q;
		e = 8'(qe);
		{oe_n, cs_n, al} = 3'h7;
	endtask
endmodule

/* testbench/byte_eeprom_host_port_tb.sv */
// self-checking bench of the byte eeprom host port
`timescale 1ns/100ps
module byte_eeprom_host_port_tb;
	logic        clk_sys = 0;
	logic        reset_n = 0;
	logic        cs_n, oe_n, we_n, al, pt, qe, ready;
	logic [6:0]  a;
	logic [7:0]  di, q, r, e;
	int          bad_count = 0, cmp_count = 0, cyc_n = 0, pe = 0;
	logic [14:0] rows [3] = '{{7'h00, 8'h5a}, {7'h7f, 8'ha5}, {7'h2c, 8'h00}};
	always #10 clk_sys = ~clk_sys;
	always @(posedge pt) if (ready === 1'b0) pe++;
	always @(posedge clk_sys) begin
		cyc_n++;
		if (cyc_n == 40000) begin
			bad_count++;
			complete_run();
		end
	end
	bep_eeprom u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .chip_sel_n(cs_n),
		.out_gate_n(oe_n), .wr_strobe_n(we_n), .addr_latch(al),
		.word_select_lines(a), .byte_io_lines_in(di), .byte_io_lines_out(q),
		.byte_io_lines_oe(qe), .prog_timing(pt), .ready(ready));
	bep_host u_host (.clk_sys(clk_sys), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
		.al(al), .a(a), .di(di), .pt(pt), .q(q), .qe(qe));
	task chk(input logic [7:0] g, x);
		cmp_count++;
		if (g !== x) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, g, x);
		end
	endtask
	task complete_run();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wait_rdy();
		for (int n = 0; ready !== 1'b1 && n < 6000; n++) begin
			@(posedge clk_sys);
			#2;
		end
		chk(8'(ready), 8'h01);
	endtask
	task wrt(input logic [6:0] x, logic [7:0] d, logic m);
		pe = 0;
		u_host.wr(x, d, 1'b0, m);
		chk(8'(ready), 8'h00);
		wait_rdy();
		chk(8'(pe >= 1023 && pe <= 1025), 8'h01);
	endtask
	task rdc(input logic [6:0] x, logic [7:0] d);
		u_host.rd(x, 1'b0, 1'b0, 1'b0, r, e);
		chk(r, d);
		chk(e, 8'h01);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		#2;
		reset_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		chk(8'(ready), 8'h01);
		chk(8'(qe), 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			wrt(rows[i][14:8], rows[i][7:0], 1'b0);
			rdc(rows[i][14:8], rows[i][7:0]);
		end
		$display("test rows done");
		u_host.rd(7'h00, 1'b1, 1'b0, 1'b0, r, e);
		chk(e, 8'h00);
		u_host.rd(7'h00, 1'b0, 1'b1, 1'b0, r, e);
		chk(e, 8'h00);
		u_host.wr(7'h10, 8'h33, 1'b1, 1'b0);
		chk(8'(ready), 8'h01);
		rdc(7'h10, 8'hff);
		wrt(7'h11, 8'h3c, 1'b1);
		rdc(7'h11, 8'h3c);
		rdc(7'h6e, 8'hff);
		u_host.rd(7'h11, 1'b0, 1'b0, 1'b1, r, e);
		chk(r, 8'h3c);
		chk(e, 8'h01);
		u_host.wr(7'h12, 8'h99, 1'b0, 1'b0);
		u_host.wr(7'h13, 8'h77, 1'b0, 1'b0);
		wait_rdy();
		rdc(7'h12, 8'h99);
		rdc(7'h13, 8'hff);
		$display("test awkward done");
		complete_run();
	end
endmodule
